// ===== logic/ptwd_dcount.sv
// Purpose: loadable down-counter that stops at zero
// Assumes: load has priority over decrement
// Notes: used for the periodic timer and the watchdog
`timescale 1ns/1ns
`default_nettype none
module ptwd_dcount #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] load_val_in,
	input wire logic dec_in,
	output logic [WIDTH-1:0] count_out,
	output logic zero_out
);
	logic [WIDTH-1:0] count_q;

	assign count_out = count_q;
	assign zero_out = (count_q == '0);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_q <= RST_VAL;
		end else if (load_in) begin
			count_q <= load_val_in;
		end else if (dec_in && !zero_out) begin
			count_q <= count_q - 1'b1;
		end
	end

	a_dec_by_one: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(dec_in && !load_in && !zero_out) |=>
		count_q == $past(count_q) - 1'b1)
		else $error("counter did not step down by one");
endmodule : ptwd_dcount
`default_nettype wire

// ===== logic/ptwd_pkg.sv
// Purpose: shared types of the periodic timer and watchdog
// Assumes: nothing
// Notes: numeric constants live in ptwd_regs.svh
package ptwd_pkg;

	// ============================================================
	// watchdog state, one-hot
	typedef enum logic [1:0] {
		WD_IDLE = 2'b01,
		WD_RUN = 2'b10
	} ptwd_wd_state_type;

	// ============================================================
	// timer_watchdog_config layout, bit 5 down to bit 0
	typedef struct packed {
		logic match_service_enable;
		logic watchdog_clock_select;
		logic lock_wd_count;
		logic lock_timer;
		logic lock_prescale;
		logic lock_config;
	} ptwd_cfg_type;

	// ============================================================
	// watchdog cause flags
	typedef struct packed {
		logic late;
		logic early;
		logic wrong;
	} ptwd_cause_type;

endpackage : ptwd_pkg

// ===== logic/ptwd_prescale.sv
// Purpose: power-of-two divider of low-frequency edges
// Assumes: lf_edge_in is a one-cycle pulse per low-frequency rising edge
// Notes: reserved exponents divide by the largest ratio
`timescale 1ns/1ns
`default_nettype none
`include "ptwd_regs.svh"
module ptwd_prescale (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic lf_edge_in,
	input wire logic [`PTWD_EXP_W-1:0] exp_in,
	output logic tick_out
);
	logic [`PTWD_PRESCALE_W-1:0] cnt_q;
	logic [`PTWD_PRESCALE_W-1:0] mask;

	always_comb begin
		case (exp_in)
			3'h0: mask = 5'h00;
			3'h1: mask = 5'h01;
			3'h2: mask = 5'h03;
			3'h3: mask = 5'h07;
			3'h4: mask = 5'h0F;
			default: mask = 5'h1F;
		endcase
	end

	assign tick_out = lf_edge_in && ((cnt_q & mask) == mask);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= 5'h00;
		end else if (lf_edge_in) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	a_tick_on_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tick_out |-> lf_edge_in)
		else $error("prescaled tick without low-frequency edge");
endmodule : ptwd_prescale
`default_nettype wire

// ===== logic/ptwd_regs.svh
// Purpose: register offsets, field positions, reset values, restart pattern
// Assumes: 8-bit register address, 16-bit data path
// Notes: included by the design files
`ifndef PTWD_REGS_SVH
`define PTWD_REGS_SVH

// ============================================================
// offsets
`define PTWD_ADDR_W 8
`define PTWD_DATA_W 16
`define PTWD_OFF_CONFIG 8'h00
`define PTWD_OFF_PRESCALE 8'h04
`define PTWD_OFF_RELOAD 8'h08
`define PTWD_OFF_CSR 8'h0C
`define PTWD_OFF_WD_COUNT 8'h10
`define PTWD_OFF_WD_MATCH 8'h14
`define PTWD_OFF_TIMER_VALUE 8'h18
`define PTWD_OFF_WD_STATUS 8'h1C

// ============================================================
// fields
`define PTWD_CSR_RESTART_BIT 0
`define PTWD_CSR_TC_BIT 1
`define PTWD_CFG_W 6
`define PTWD_CFG_LOCK_MASK 6'h0F
`define PTWD_EXP_W 3
`define PTWD_EXP_MAX 3'h5
`define PTWD_PRESCALE_W 5

// ============================================================
// reset values and patterns
`define PTWD_RELOAD_RST 16'hFFFF
`define PTWD_WD_COUNT_RST 8'h0F
`define PTWD_RESTART_PATTERN 8'h5C
`define PTWD_CFG_RST 6'h00
`define PTWD_EXP_RST 3'h0

`endif

// ===== logic/ptwd_top.sv
// Purpose: periodic tick timer and watchdog behind a plain register port
// Assumes: lf_clk_in and wd_alt_clk_in are slow levels synchronous to clk_in
// Notes: 20 MHz system clock; counting advances on low-frequency edges
`timescale 1ns/1ns
`default_nettype none
`include "ptwd_regs.svh"
module ptwd_top
	import ptwd_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic lf_clk_in,
	input wire logic wd_alt_clk_in,
	input wire logic wd_alt_sel_in,
	input wire logic [`PTWD_ADDR_W-1:0] addr_in,
	input wire logic [`PTWD_DATA_W-1:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [`PTWD_DATA_W-1:0] rd_data_out,
	output logic periodic_tick_out,
	output logic watchdog_signal_out,
	output logic watchdog_running_out
);
	// ============================================================
	// state
	logic lf_q;
	logic alt_q;
	ptwd_cfg_type cfg_q;
	logic [`PTWD_EXP_W-1:0] exp_q;
	logic [15:0] reload_q;
	logic restart_q;
	logic tc_q;
	logic tick_q;
	logic [7:0] wd_reload_q;
	ptwd_wd_state_type wd_state_q;
	logic svc_flag_q;
	logic wd_sig_q;
	ptwd_cause_type cause_q;
	logic [`PTWD_DATA_W-1:0] rd_data_q;

	// ============================================================
	// edges of the slow clocks
	wire lf_edge = lf_clk_in && !lf_q;
	wire alt_edge = wd_alt_clk_in && !alt_q;

	// ============================================================
	// write and read decode
	wire wr_cfg = wr_in && addr_in == `PTWD_OFF_CONFIG && !cfg_q.lock_config;
	wire wr_exp = wr_in && addr_in == `PTWD_OFF_PRESCALE &&
		!cfg_q.lock_prescale;
	wire wr_reload = wr_in && addr_in == `PTWD_OFF_RELOAD &&
		!cfg_q.lock_timer;
	wire wr_csr = wr_in && addr_in == `PTWD_OFF_CSR && !cfg_q.lock_timer;
	wire wr_watchdog_reload_count = wr_in && addr_in == `PTWD_OFF_WD_COUNT &&
		!cfg_q.lock_wd_count;
	wire wr_match = wr_in && addr_in == `PTWD_OFF_WD_MATCH &&
		cfg_q.match_service_enable;
	wire rd_csr = rd_in && addr_in == `PTWD_OFF_CSR;
	wire match_ok = wr_match &&
		wr_data_in[7:0] == `PTWD_RESTART_PATTERN;
	wire match_bad = wr_match &&
		wr_data_in[7:0] != `PTWD_RESTART_PATTERN;
	wire match_early = match_ok && svc_flag_q;

	// ============================================================
	// prescaler and periodic counter
	wire ptick;
	wire [15:0] pcount;
	wire pzero;
	wire p_load = ptick && (pzero || restart_q);
	wire [`PTWD_CFG_W-1:0] cfg_wr = wr_data_in[`PTWD_CFG_W-1:0];
	wire [`PTWD_CFG_W-1:0] cfg_locks = cfg_q & `PTWD_CFG_LOCK_MASK;

	ptwd_prescale u_prescale (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.lf_edge_in(lf_edge),
		.exp_in(exp_q),
		.tick_out(ptick)
	);

	ptwd_dcount #(
		.WIDTH(16),
		.RST_VAL(`PTWD_RELOAD_RST)
	) u_periodic (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.load_in(p_load),
		.load_val_in(reload_q),
		.dec_in(ptick),
		.count_out(pcount),
		.zero_out(pzero)
	);

	// ============================================================
	// watchdog counter
	wire wd_running = wd_state_q == WD_RUN;
	wire wd_tick = wd_alt_sel_in ? alt_edge :
		(cfg_q.watchdog_clock_select ? ptick : ptick && pzero);
	wire wd_load = wr_watchdog_reload_count || match_ok;
	wire [7:0] wd_load_val = wr_watchdog_reload_count ? wr_data_in[7:0] : wd_reload_q;
	wire [7:0] wd_count;
	wire wd_zero;
	wire wd_late = wd_running && wd_zero && !wd_load;
	wire wd_fire = wd_late || match_bad || match_early;

	ptwd_dcount #(
		.WIDTH(8),
		.RST_VAL(`PTWD_WD_COUNT_RST)
	) u_watchdog (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.load_in(wd_load),
		.load_val_in(wd_load_val),
		.dec_in(wd_tick && wd_running),
		.count_out(wd_count),
		.zero_out(wd_zero)
	);

	// ============================================================
	// next values
	wire restart_d = (wr_csr && wr_data_in[`PTWD_CSR_RESTART_BIT]) ||
		(restart_q && !ptick);
	wire tc_d = (ptick && pzero) || (tc_q && !rd_csr);
	wire svc_d = match_ok || (svc_flag_q && !wd_tick);
	ptwd_wd_state_type wd_state_d;

	always_comb begin
		case (wd_state_q)
			WD_IDLE: wd_state_d = wd_load ? WD_RUN : WD_IDLE;
			WD_RUN: wd_state_d = WD_RUN;
			default: wd_state_d = WD_IDLE;
		endcase
	end

	// ============================================================
	// read mux; write-only registers and locked config, prescale and reload read zero
	logic [`PTWD_DATA_W-1:0] rd_mux;
	always_comb begin
		case (addr_in)
			`PTWD_OFF_CONFIG: rd_mux = cfg_q.lock_config ? 16'h0000 :
				{10'h000, cfg_q};
			`PTWD_OFF_PRESCALE: rd_mux = cfg_q.lock_prescale ? 16'h0000 :
				{13'h0000, exp_q};
			`PTWD_OFF_RELOAD: rd_mux = cfg_q.lock_timer ? 16'h0000 :
				reload_q;
			`PTWD_OFF_CSR: rd_mux = {14'h0000, tc_q, restart_q};
			`PTWD_OFF_TIMER_VALUE: rd_mux = pcount;
			`PTWD_OFF_WD_STATUS: rd_mux = {wd_sig_q, cause_q, 3'h0,
				wd_running, wd_count};
			default: rd_mux = 16'h0000;
		endcase
	end

	// ============================================================
	// flops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// high, so a level already high at release is no false edge
			lf_q <= 1'b1;
			alt_q <= 1'b1;
		end else begin
			lf_q <= lf_clk_in;
			alt_q <= wd_alt_clk_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_q <= `PTWD_CFG_RST;
			exp_q <= `PTWD_EXP_RST;
			reload_q <= `PTWD_RELOAD_RST;
			wd_reload_q <= `PTWD_WD_COUNT_RST;
		end else begin
			if (wr_cfg) begin
				cfg_q <= cfg_wr | cfg_locks;
			end
			if (wr_exp) begin
				exp_q <= wr_data_in[`PTWD_EXP_W-1:0];
			end
			if (wr_reload) begin
				reload_q <= wr_data_in;
			end
			if (wr_watchdog_reload_count) begin
				wd_reload_q <= wr_data_in[7:0];
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			restart_q <= 1'b0;
			tc_q <= 1'b0;
			tick_q <= 1'b0;
			svc_flag_q <= 1'b0;
			wd_state_q <= WD_IDLE;
		end else begin
			restart_q <= restart_d;
			tc_q <= tc_d;
			tick_q <= ptick ? pzero : tick_q;
			svc_flag_q <= svc_d;
			wd_state_q <= wd_state_d;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wd_sig_q <= 1'b0;
			cause_q <= '0;
			rd_data_q <= 16'h0000;
		end else begin
			wd_sig_q <= wd_sig_q || wd_fire;
			cause_q <= cause_q | {wd_late, match_early, match_bad};
			rd_data_q <= rd_in ? rd_mux : 16'h0000;
		end
	end

	assign rd_data_out = rd_data_q;
	assign periodic_tick_out = tick_q;
	assign watchdog_signal_out = wd_sig_q;
	assign watchdog_running_out = wd_state_q == WD_RUN;

	// ============================================================
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_service;
		match_ok ##1 !wd_tick;
	endsequence

	sequence s_second_service;
		s_service ##1 match_ok;
	endsequence

	a_reload_write: assert property (wr_reload |=>
		reload_q == $past(wr_data_in))
		else $error("reload value not stored");
	a_reload_at_zero: assert property (ptick && pzero |=>
		pcount == $past(reload_q))
		else $error("periodic counter did not reload");
	a_restart_done: assert property (ptick && restart_q && !wr_csr |=>
		!restart_q && pcount == $past(reload_q))
		else $error("restart not carried out");
	a_tick_window: assert property (ptick && pzero |=>
		periodic_tick_out until_with ptick)
		else $error("tick output not held for one prescaled cycle");
	a_tc_set_clear: assert property ((ptick && pzero |=> tc_q) and
		(rd_csr && !(ptick && pzero) |=> !tc_q))
		else $error("terminal count flag wrong");
	a_count_start: assert property (wr_watchdog_reload_count |=> watchdog_running_out &&
		wd_count == $past(wr_data_in[7:0]))
		else $error("watchdog count write did not start countdown");
	a_match_restart: assert property (match_ok && !svc_flag_q |=>
		wd_count == $past(wd_reload_q) && watchdog_running_out)
		else $error("match service did not restart");
	a_match_wrong: assert property (match_bad |=>
		watchdog_signal_out)
		else $error("wrong pattern did not fire watchdog");
	a_early_service: assert property (s_second_service |=>
		watchdog_signal_out)
		else $error("early service did not fire watchdog");
	a_match_ignored: assert property (wr_in &&
		addr_in == `PTWD_OFF_WD_MATCH && !cfg_q.match_service_enable &&
		!watchdog_running_out && !watchdog_signal_out |=>
		!watchdog_running_out && !watchdog_signal_out)
		else $error("disabled match write had an effect");
	a_wd_sticky: assert property (watchdog_running_out |=>
		watchdog_running_out)
		else $error("watchdog stopped without reset");
	a_wd_expire: assert property (watchdog_running_out && wd_zero &&
		!wd_load |=> watchdog_signal_out)
		else $error("expiry did not fire watchdog");
	a_lock_holds: assert property (|cfg_locks |=>
		((cfg_q & `PTWD_CFG_LOCK_MASK) & $past(cfg_locks)) ==
		$past(cfg_locks))
		else $error("lock bit lost");
	a_locked_reload: assert property (cfg_q.lock_timer |=>
		$stable(reload_q))
		else $error("locked reload changed");
endmodule : ptwd_top
`default_nettype wire

// ===== verification/ptwd_fw_model.sv
// Purpose: firmware model driving the register port
// Assumes: one-cycle strobes, read data in the cycle after rd
// Notes: tasks are called from tb_top
`timescale 1ns/1ns
`default_nettype none
`include "ptwd_regs.svh"
module ptwd_fw_model (
	input wire logic clk_in,
	input wire logic [`PTWD_DATA_W-1:0] rd_data_in,
	output logic [`PTWD_ADDR_W-1:0] addr_out,
	output logic [`PTWD_DATA_W-1:0] wr_data_out,
	output logic wr_out,
	output logic rd_out
);
	initial begin
		addr_out = 8'h00;
		wr_data_out = 16'h0000;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// ============================================================
	// bus cycles
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wr_data_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wr_data_out <= ~d;
		#1;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a, output logic [15:0] q);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1;
		q = rd_data_in;
	endtask : bus_rd
	// ============================================================
	// firmware sequences
	task automatic arm(input logic [15:0] cfg, input logic [7:0] cnt);
		bus_wr(`PTWD_OFF_CONFIG, cfg);
		bus_wr(`PTWD_OFF_WD_COUNT, {8'h00, cnt});
	endtask : arm
	task automatic service(input int gap);
		repeat (gap) @(posedge clk_in);
		bus_wr(`PTWD_OFF_WD_MATCH, 16'h005C);
	endtask : service
endmodule : ptwd_fw_model
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: self-checking bench of the timer and watchdog
// Assumes: slow clock emulated as an 8-cycle level, alt clock 6 cycles
// Notes: watchdog faults are sticky, so each case starts from reset
`timescale 1ns/1ns
`default_nettype none
`include "ptwd_regs.svh"
module tb_top;
	import ptwd_pkg::*;
	logic clk_in;
	logic rst_n_in;
	logic wd_alt_sel_in;
	logic [2:0] lf_div = 3'd0;
	logic [2:0] alt_div = 3'd0;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic wr;
	logic rd;
	logic tick;
	logic wsig;
	logic wrun;
	int fails = 0;
	int tests_run = 0;
	wire logic lf_clk_in = lf_div[2];
	wire logic wd_alt_clk_in = (alt_div < 3'd3);
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		lf_div <= lf_div + 3'd1;
		alt_div <= (alt_div == 3'd5) ? 3'd0 : alt_div + 3'd1;
	end
	ptwd_fw_model fw_i (.clk_in(clk_in), .rd_data_in(rdata),
		.addr_out(addr), .wr_data_out(wdata), .wr_out(wr), .rd_out(rd));
	ptwd_top ptwd_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.lf_clk_in(lf_clk_in), .wd_alt_clk_in(wd_alt_clk_in),
		.wd_alt_sel_in(wd_alt_sel_in), .addr_in(addr), .wr_data_in(wdata),
		.wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
		.periodic_tick_out(tick), .watchdog_signal_out(wsig),
		.watchdog_running_out(wrun));
	// ============================================================
	// helpers
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wait_tick(input logic v, output int n);
		n = 0;
		while (tick !== v) begin
			@(posedge clk_in);
			#1;
			n++;
			if (n > 3000) begin
				fails++;
				summarize();
			end
		end
	endtask : wait_tick
	task automatic wait_sig(input int lim, output int n);
		n = 0;
		while (wsig !== 1'b1) begin
			@(posedge clk_in);
			#1;
			n++;
			if (n > lim) begin
				fails++;
				summarize();
			end
		end
	endtask : wait_sig
	// ============================================================
	// watchdog cases: 0/1 late, 2 wrong, 3 early, 4 serviced, 5 locked
	task automatic wd_case(input int k);
		logic [15:0] q;
		logic [7:0] cnt;
		int n;
		int p;
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		wd_alt_sel_in <= (k == 1);
		cnt = 8'($urandom_range(8, 3));
		p = (k == 1) ? 6 : 8;
		if (k == 5) begin
			fw_i.bus_wr(`PTWD_OFF_CONFIG, 16'h000F);
			fw_i.bus_wr(`PTWD_OFF_RELOAD, 16'h0001);
			fw_i.bus_rd(`PTWD_OFF_RELOAD, q);
			check("reload_lock", q, 16'h0000);
		end
		// early case counts on the periodic tick, so no tick between services
		fw_i.arm((k == 3) ? 16'h0020 : 16'h0030,
			(k == 2 || k == 3) ? 8'h40 : cnt);
		check("running", {15'h0, wrun}, {15'h0, k != 5});
		if (k <= 1) begin
			wait_sig(200, n);
			check("late_win", 16'(n >= (cnt - 1) * p && n <= (cnt + 1) * p + 4),
				16'h0001);
		end else if (k == 2) begin
			fw_i.bus_wr(`PTWD_OFF_WD_MATCH, 16'($urandom_range(255, 93)));
			wait_sig(4, n);
		end else if (k == 3) begin
			fw_i.service(12);
			fw_i.service(0);
			wait_sig(4, n);
		end else begin
			for (int i = 0; i < 30; i++) begin
				fw_i.service(8);
			end
			// match service off, then a stray byte must be ignored
			fw_i.bus_wr(`PTWD_OFF_CONFIG, 16'h0010);
			fw_i.bus_wr(`PTWD_OFF_WD_MATCH, 16'h0000);
			repeat (4) @(posedge clk_in);
		end
		fw_i.bus_rd(`PTWD_OFF_WD_STATUS, q);
		case (k)
			0, 1: check("wd_status", q, 16'hC100);
			2: check("wd_cause", {12'h0, q[15:12]}, 16'h0009);
			3: check("wd_cause", {12'h0, q[15:12]}, 16'h000A);
			4: check("wd_ok", {q[15:12], 3'h0, q[8]}, 5'h01);
			default: check("wd_lock", q, 16'h000F);
		endcase
	endtask : wd_case
	// ============================================================
	// main sequence
	initial begin
		logic [7:0] ra[5];
		logic [15:0] rv[5];
		logic [15:0] q;
		logic [15:0] r;
		int hi;
		int lo;
		ra = '{`PTWD_OFF_RELOAD, `PTWD_OFF_CSR, `PTWD_OFF_WD_STATUS,
			`PTWD_OFF_WD_COUNT, 8'h20};
		rv = '{16'hFFFF, 16'h0000, 16'h000F, 16'h0000, 16'h0000};
		rst_n_in = 1'b0;
		wd_alt_sel_in = 1'b0;
		void'($urandom(53));
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			fw_i.bus_rd(ra[i], q);
			check("reset_val", q, rv[i]);
		end
		r = 16'($urandom_range(65535, 1));
		fw_i.bus_wr(`PTWD_OFF_RELOAD, r);
		fw_i.bus_rd(`PTWD_OFF_RELOAD, q);
		check("reload_rw", q, r);
		for (int e = 0; e <= 5; e++) begin
			r = 16'($urandom_range(3, 1));
			fw_i.bus_wr(`PTWD_OFF_PRESCALE, 16'(e));
			fw_i.bus_wr(`PTWD_OFF_RELOAD, r);
			fw_i.bus_wr(`PTWD_OFF_CSR, 16'h0001);
			// skip the first pulse, it may mix old and new settings
			wait_tick(1'b0, hi);
			wait_tick(1'b1, hi);
			wait_tick(1'b0, hi);
			wait_tick(1'b1, hi);
			wait_tick(1'b0, hi);
			wait_tick(1'b1, lo);
			check("tick_high", 16'(hi), 16'(8 << e));
			check("tick_per", 16'(hi + lo), 16'((r + 1) * (8 << e)));
			fw_i.bus_rd(`PTWD_OFF_CSR, q);
			check("csr_tc", q, 16'h0002);
			fw_i.bus_wr(`PTWD_OFF_CSR, 16'h0002);
			fw_i.bus_rd(`PTWD_OFF_CSR, q);
			check("csr_clr", q, 16'h0000);
		end
		for (int k = 0; k < 6; k++) begin
			wd_case(k);
		end
		summarize();
	end
endmodule : tb_top
`default_nettype wire
